// file: pkg/psr_regs.vh
// Purpose: Offsets, keys, encodings and reset values of the parameter save/restore block
// Assumes: Register port with a 6-bit word address and 32-bit data
// Notes: Definitions only
`ifndef PSR_REGS_VH
`define PSR_REGS_VH

// ****************************************************************
// Register offsets (word index)
// ****************************************************************
`define PSR_SAVE_BASE 6'h00
`define PSR_DISC_BASE 6'h10
`define PSR_BOOT_OFS 6'h21
`define PSR_MARK_DATE_OFS 6'h30
`define PSR_MARK_TIME_OFS 6'h31
`define PSR_IRQ_STAT_OFS 6'h38
`define PSR_IRQ_EN_OFS 6'h39
`define PSR_IRQ_CLR_OFS 6'h3a
`define PSR_STATUS_OFS 6'h3b

// ****************************************************************
// Keys and values
// ****************************************************************
`define PSR_KEY_SAVE 32'h65766173
`define PSR_KEY_DISCARD 32'h64616f6c
`define PSR_KEY_BOOT 32'h746f6f62
`define PSR_SAVE_DONE_VAL 32'h00000001
`define PSR_CMD_RST 32'h00000000
`define PSR_MARK_CLR 32'h00000000

// ****************************************************************
// Subindices and category masks
// ****************************************************************
`define PSR_NUM_SUB 6
`define PSR_SUB_ALL 3'h1
`define PSR_SUB_TUNING 3'h6
`define PSR_MASK_W 6
`define PSR_MASK_NONE 6'h00
`define PSR_MASK_SAVE_ALL 6'h3f
`define PSR_MASK_DISC_ALL 6'h0f
`define PSR_MASK_LOAD_ALL 6'h3f

// ****************************************************************
// Memory operations
// ****************************************************************
`define PSR_OP_LOAD 2'h0
`define PSR_OP_SAVE 2'h1
`define PSR_OP_ERASE 2'h2

// ****************************************************************
// Interrupt bits
// ****************************************************************
`define PSR_IRQ_W 4
`define PSR_IRQ_SAVE 0
`define PSR_IRQ_ERASE 1
`define PSR_IRQ_LOAD 2
`define PSR_IRQ_REFUSED 3

`endif

// file: src/psr_cmd_slot.v
// Purpose: One command word of a save or discard subindex
// Assumes: Writes are single-cycle strobes
// Notes: Reports a key match on write; can be overwritten with the completion value
`timescale 1ns/100ps
`default_nettype none
`include "psr_regs.vh"

module psr_cmd_slot #(
	parameter [31:0] KEY = 32'h00000000
) (
	input wire clk,
	input wire srst,
	input wire ce,
	input wire wr,
	input wire [31:0] wdata,
	input wire set_done,
	output wire key_hit,
	output wire [31:0] value
);
	reg [31:0] value_reg;

	// Only the exact key counts; any other value is just stored
	assign key_hit = wr & (wdata == KEY); // [R16]
	assign value = value_reg;

	always @(posedge clk) begin
		if (srst) begin
			value_reg <= `PSR_CMD_RST;
		end else if (ce) begin
			if (set_done) begin
				value_reg <= `PSR_SAVE_DONE_VAL; // [R2]
			end else if (wr) begin
				value_reg <= wdata;
			end
		end
	end
endmodule // psr_cmd_slot

`default_nettype wire

// file: src/psr_nvm_seq.v
// Purpose: Runs one category-level operation at a time on the non-volatile store
// Assumes: Store answers each request with a one-cycle done pulse
// Notes: A load of every category starts by itself after reset
`timescale 1ns/100ps
`default_nettype none
`include "psr_regs.vh"

module psr_nvm_seq (
	input wire clk,
	input wire srst,
	input wire ce,
	input wire start,
	input wire [1:0] op_in,
	input wire [5:0] mask_in,
	input wire nvm_done,
	output wire nvm_req,
	output wire [1:0] nvm_op,
	output wire [5:0] nvm_cat,
	output wire busy,
	output wire done,
	output wire [1:0] done_op
);
	localparam ST_IDLE = 1'b0;
	localparam ST_RUN = 1'b1;

	reg state_reg;
	reg [1:0] op_reg;
	reg [5:0] cat_reg;
	reg done_reg;

	assign nvm_req = (state_reg == ST_RUN);
	assign nvm_op = op_reg;
	assign nvm_cat = cat_reg;
	assign busy = (state_reg == ST_RUN);
	assign done = done_reg;
	assign done_op = op_reg;

	always @(posedge clk) begin
		if (srst) begin
			// Reload every saved category after reset
			state_reg <= ST_RUN; // [R15]
			op_reg <= `PSR_OP_LOAD;
			cat_reg <= `PSR_MASK_LOAD_ALL;
			done_reg <= 1'b0;
		end else if (ce) begin
			done_reg <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (start) begin
						state_reg <= ST_RUN;
						op_reg <= op_in;
						cat_reg <= mask_in; // [R14]
					end
				end
				default: begin
					if (nvm_done) begin
						state_reg <= ST_IDLE;
						done_reg <= 1'b1;
					end
				end
			endcase
		end
	end
endmodule // psr_nvm_seq

`default_nettype wire

// file: src/psr_ctrl.v
// Purpose: Parameter save/discard/restart control with modification marker
// Assumes: Register port strobes are synchronous and never both high
// Notes: Working values are never touched here; erased data applies at restart
`timescale 1ns/100ps
`default_nettype none
`include "psr_regs.vh"

// Overview of operation
// R1: Save key on subindex saves category
// R2: Finished save writes value 1 back
// R3: Subindex 1 all, 2-6 single categories
// R4: Discard key erases that category's saved data
// R5: Discard keeps working values until restart
// R6: Boot key on boot register restarts device
// R7: Discard-all spares tuning; subindex 6 erases it
// R8: Marker writable; save-all stores it too
// R9: Savable writes clear marker, with stated exceptions
// R10: Master reads marker 0 as changed
// R11: Master keeps motor stopped during save
// R12: Master polls until value 1 returns
// R13: Master configures, sets marker, then saves all
// R14: Only whole categories are saved
// R15: Reset reloads all saved categories
// R16: Non-key values start no operation
module psr_ctrl (
	input wire clk,
	input wire srst,
	input wire ce,
	input wire [5:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output wire [31:0] rdata,
	input wire obj_wr_savable,
	output wire nvm_req,
	output wire [1:0] nvm_op,
	output wire [5:0] nvm_cat,
	output wire [31:0] nvm_mark_date,
	output wire [31:0] nvm_mark_time,
	input wire nvm_done,
	input wire [31:0] nvm_load_date,
	input wire [31:0] nvm_load_time,
	output wire restart_req,
	output wire irq
);
	// ****************************************************************
	// Declarations
	// ****************************************************************
	wire [`PSR_NUM_SUB:1] save_wr;
	wire [`PSR_NUM_SUB:1] disc_wr;
	wire [`PSR_NUM_SUB:1] save_hit;
	wire [`PSR_NUM_SUB:1] disc_hit;
	wire [`PSR_NUM_SUB:1] save_set;
	wire [31:0] save_val [1:`PSR_NUM_SUB];
	wire [31:0] disc_val [1:`PSR_NUM_SUB];
	wire [5:0] sub_mask [1:`PSR_NUM_SUB];
	wire seq_busy;
	wire seq_done;
	wire [1:0] seq_done_op;
	wire any_hit;
	wire refused;
	wire mark_clear;
	wire boot_hit;
	reg start;
	reg [1:0] start_op;
	reg [5:0] start_mask;
	reg [2:0] start_sub;
	reg [2:0] pend_sub_reg;
	reg [31:0] mark_date_reg;
	reg [31:0] mark_time_reg;
	reg [31:0] rdata_reg;
	reg [31:0] rdata_next;
	reg restart_reg;
	reg [`PSR_IRQ_W-1:0] irq_stat_reg;
	reg [`PSR_IRQ_W-1:0] irq_en_reg;
	reg [`PSR_IRQ_W-1:0] irq_set;
	reg [`PSR_IRQ_W-1:0] irq_clr;
	integer i;

	// ****************************************************************
	// Command subindices
	// ****************************************************************
	genvar g;
	generate
		for (g = 1; g <= `PSR_NUM_SUB; g = g + 1) begin : g_sub
			assign save_wr[g] = wr & (addr == (`PSR_SAVE_BASE + g));
			assign disc_wr[g] = wr & (addr == (`PSR_DISC_BASE + g));
			// Subindex 1 covers every category, the others one bit each
			if (g == 1) begin : g_all
				assign sub_mask[g] = `PSR_MASK_SAVE_ALL; // [R3]
			end else begin : g_one
				assign sub_mask[g] = 6'h01 << (g - 2); // [R3]
			end
			assign save_set[g] = seq_done & (seq_done_op == `PSR_OP_SAVE) &
				(pend_sub_reg == g);

			psr_cmd_slot #(
				.KEY(`PSR_KEY_SAVE)
			) u_save (
				.clk(clk),
				.srst(srst),
				.ce(ce),
				.wr(save_wr[g]),
				.wdata(wdata),
				.set_done(save_set[g]), // [R2]
				.key_hit(save_hit[g]),
				.value(save_val[g])
			);

			psr_cmd_slot #(
				.KEY(`PSR_KEY_DISCARD)
			) u_disc (
				.clk(clk),
				.srst(srst),
				.ce(ce),
				.wr(disc_wr[g]),
				.wdata(wdata),
				.set_done(1'b0),
				.key_hit(disc_hit[g]),
				.value(disc_val[g])
			);
		end
	endgenerate

	// ****************************************************************
	// Operation start
	// ****************************************************************
	// A single write carries at most one key, so only one hit is live
	always @* begin
		start_op = `PSR_OP_SAVE;
		start_mask = `PSR_MASK_NONE;
		start_sub = 3'h0;
		for (i = 1; i <= `PSR_NUM_SUB; i = i + 1) begin
			if (save_hit[i]) begin
				start_op = `PSR_OP_SAVE; // [R1]
				start_mask = sub_mask[i]; // [R8]
				start_sub = i[2:0];
			end else if (disc_hit[i]) begin
				start_op = `PSR_OP_ERASE; // [R4]
				start_sub = i[2:0];
				// Erase-all leaves tuning and marker untouched
				if (i[2:0] == `PSR_SUB_ALL) begin
					start_mask = `PSR_MASK_DISC_ALL; // [R7]
				end else begin
					start_mask = sub_mask[i]; // [R7]
				end
			end
		end
		start = any_hit & ~seq_busy;
	end

	assign any_hit = (|save_hit) | (|disc_hit);
	// A key that arrives while the store is busy starts nothing
	assign refused = any_hit & seq_busy;

	psr_nvm_seq u_seq (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.start(start), // [R5]
		.op_in(start_op),
		.mask_in(start_mask), // [R14]
		.nvm_done(nvm_done),
		.nvm_req(nvm_req),
		.nvm_op(nvm_op),
		.nvm_cat(nvm_cat),
		.busy(seq_busy),
		.done(seq_done),
		.done_op(seq_done_op)
	);

	always @(posedge clk) begin
		if (srst) begin
			pend_sub_reg <= 3'h0;
		end else if (ce) begin
			if (start) begin
				pend_sub_reg <= (start_op == `PSR_OP_SAVE) ? start_sub : 3'h0;
			end
		end
	end

	// ****************************************************************
	// Restart request
	// ****************************************************************
	assign boot_hit = wr & (addr == `PSR_BOOT_OFS) & (wdata == `PSR_KEY_BOOT);
	assign restart_req = restart_reg;

	always @(posedge clk) begin
		if (srst) begin
			restart_reg <= 1'b0;
		end else if (ce) begin
			restart_reg <= boot_hit; // [R6]
		end
	end

	// ****************************************************************
	// Modification marker
	// ****************************************************************
	// Save-all subindex and the marker itself do not clear it
	assign mark_clear = obj_wr_savable | (|save_wr[`PSR_NUM_SUB:2]); // [R9]
	assign nvm_mark_date = mark_date_reg;
	assign nvm_mark_time = mark_time_reg;

	always @(posedge clk) begin
		if (srst) begin
			mark_date_reg <= `PSR_MARK_CLR;
			mark_time_reg <= `PSR_MARK_CLR;
		end else if (ce) begin
			if (seq_done & (seq_done_op == `PSR_OP_LOAD)) begin
				mark_date_reg <= nvm_load_date; // [R15]
				mark_time_reg <= nvm_load_time;
			end else if (wr & (addr == `PSR_MARK_DATE_OFS)) begin
				mark_date_reg <= wdata; // [R8]
			end else if (wr & (addr == `PSR_MARK_TIME_OFS)) begin
				mark_time_reg <= wdata; // [R8]
			end else if (mark_clear) begin
				mark_date_reg <= `PSR_MARK_CLR; // [R9]
				mark_time_reg <= `PSR_MARK_CLR; // [R9]
			end
		end
	end

	// ****************************************************************
	// Interrupts
	// ****************************************************************
	assign irq = |(irq_stat_reg & irq_en_reg);

	always @* begin
		irq_set = {`PSR_IRQ_W{1'b0}};
		irq_set[`PSR_IRQ_SAVE] = seq_done & (seq_done_op == `PSR_OP_SAVE);
		irq_set[`PSR_IRQ_ERASE] = seq_done & (seq_done_op == `PSR_OP_ERASE);
		irq_set[`PSR_IRQ_LOAD] = seq_done & (seq_done_op == `PSR_OP_LOAD);
		irq_set[`PSR_IRQ_REFUSED] = refused;
		irq_clr = {`PSR_IRQ_W{1'b0}};
		if (wr & (addr == `PSR_IRQ_CLR_OFS)) begin
			irq_clr = wdata[`PSR_IRQ_W-1:0];
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			irq_stat_reg <= {`PSR_IRQ_W{1'b0}};
			irq_en_reg <= {`PSR_IRQ_W{1'b0}};
		end else if (ce) begin
			// Set wins over a clear in the same cycle
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
			if (wr & (addr == `PSR_IRQ_EN_OFS)) begin
				irq_en_reg <= wdata[`PSR_IRQ_W-1:0];
			end
		end
	end

	// ****************************************************************
	// Read port
	// ****************************************************************
	always @* begin
		rdata_next = 32'h00000000;
		if ((addr > `PSR_SAVE_BASE) && (addr <= (`PSR_SAVE_BASE + `PSR_NUM_SUB))) begin
			rdata_next = save_val[addr[2:0]];
		end else if ((addr > `PSR_DISC_BASE) &&
			(addr <= (`PSR_DISC_BASE + `PSR_NUM_SUB))) begin
			rdata_next = disc_val[addr[2:0]];
		end else if (addr == `PSR_MARK_DATE_OFS) begin
			rdata_next = mark_date_reg;
		end else if (addr == `PSR_MARK_TIME_OFS) begin
			rdata_next = mark_time_reg;
		end else if (addr == `PSR_IRQ_STAT_OFS) begin
			rdata_next = {{(32-`PSR_IRQ_W){1'b0}}, irq_stat_reg};
		end else if (addr == `PSR_IRQ_EN_OFS) begin
			rdata_next = {{(32-`PSR_IRQ_W){1'b0}}, irq_en_reg};
		end else if (addr == `PSR_STATUS_OFS) begin
			rdata_next = {24'h000000, nvm_op, nvm_cat[4:0], seq_busy};
		end
	end

	assign rdata = rdata_reg;

	always @(posedge clk) begin
		if (srst) begin
			rdata_reg <= 32'h00000000;
		end else if (ce) begin
			rdata_reg <= rd ? rdata_next : 32'h00000000;
		end
	end
endmodule // psr_ctrl

`default_nettype wire

// file: sim/psr_ctrl_properties.sv
// Purpose: Port checks of the save/discard/restart controller
// Assumes: One clock, srst synchronous active high
// Notes: Bound to psr_ctrl from the testbench
`timescale 1ns/100ps
`default_nettype none
`include "psr_regs.vh"

module psr_ctrl_properties (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic [5:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic obj_wr_savable,
	input wire logic nvm_req,
	input wire logic [1:0] nvm_op,
	input wire logic [5:0] nvm_cat,
	input wire logic [31:0] nvm_mark_date,
	input wire logic [31:0] nvm_mark_time,
	input wire logic nvm_done,
	input wire logic restart_req
);
	// ****************************************************************
	// Helpers and properties
	// ****************************************************************
	logic idle_wr;
	logic sub_ok;
	logic boot_hit;
	logic load_end;
	logic [5:0] one_cat;
	logic [2:0] sub_q;
	assign idle_wr = wr && ce && !nvm_req && sub_ok;
	assign sub_ok = addr[2:0] != 3'h0 && addr[2:0] != 3'h7;
	assign boot_hit = wr && ce && addr == `PSR_BOOT_OFS && wdata == `PSR_KEY_BOOT;
	assign one_cat = 6'h01 << (sub_q - 3'h2);

	// Subindex of the write one cycle back, for checks made in the next cycle
	always @(posedge clk) begin
		sub_q <= addr[2:0];
	end

	// Loaded marker lands one cycle after the store's done pulse
	always @(posedge clk) begin
		if (srst) begin
			load_end <= 1'b0;
		end else if (ce) begin
			load_end <= nvm_req && nvm_done && nvm_op == `PSR_OP_LOAD;
		end
	end

	AST_SAVE_START: assert property (@(posedge clk) disable iff (srst)
		idle_wr && addr[5:3] == 3'h0 && wdata == `PSR_KEY_SAVE |=> nvm_req &&
		nvm_op == `PSR_OP_SAVE && nvm_cat == (sub_q == 3'h1 ? 6'h3f : one_cat))
		else $error("save start wrong");
	AST_DISC_START: assert property (@(posedge clk) disable iff (srst)
		idle_wr && addr[5:3] == 3'h2 && wdata == `PSR_KEY_DISCARD |=> nvm_req &&
		nvm_op == `PSR_OP_ERASE && nvm_cat == (sub_q == 3'h1 ? 6'h0f : one_cat))
		else $error("discard start wrong");
	AST_NONKEY: assert property (@(posedge clk) disable iff (srst)
		idle_wr && addr[5:3] == 3'h0 && wdata != `PSR_KEY_SAVE |=> !nvm_req)
		else $error("non-key started an op");
	AST_BOOT: assert property (@(posedge clk) disable iff (srst)
		boot_hit |=> restart_req ##1 !restart_req)
		else $error("boot key gave no restart pulse");
	AST_BOOT_ONLY: assert property (@(posedge clk) disable iff (srst)
		restart_req |-> $past(boot_hit))
		else $error("restart without boot key");
	AST_HOLD: assert property (@(posedge clk) disable iff (srst)
		nvm_req && !nvm_done |=> nvm_req && $stable(nvm_op) && $stable(nvm_cat))
		else $error("op changed before done");
	AST_MARK_CLR: assert property (@(posedge clk) disable iff (srst)
		obj_wr_savable && ce && !(wr && addr[5:1] == 5'h18) && !load_end
		|=> nvm_mark_date == 32'h0 && nvm_mark_time == 32'h0)
		else $error("marker not cleared");
	AST_MARK_KEEP: assert property (@(posedge clk) disable iff (srst)
		wr && ce && addr == 6'h01 && !obj_wr_savable && !load_end
		|=> $stable(nvm_mark_date) && $stable(nvm_mark_time))
		else $error("save-all changed marker");
	AST_LOAD_RESET: assert property (@(posedge clk)
		srst && ce |=> nvm_req && nvm_op == `PSR_OP_LOAD && nvm_cat == `PSR_MASK_LOAD_ALL)
		else $error("reset started no load");

	COV_SAVE: cover property (@(posedge clk) nvm_done && nvm_op == `PSR_OP_SAVE);
	COV_ERASE: cover property (@(posedge clk) nvm_done && nvm_op == `PSR_OP_ERASE);
	COV_BOOT: cover property (@(posedge clk) restart_req);
endmodule // psr_ctrl_properties
`default_nettype wire

// file: sim/psr_nvm_model.sv
// Purpose: Non-volatile store answering the controller
// Assumes: dly sets the wait before each done pulse
// Notes: Keeps the last saved marker and returns it on load
`timescale 1ns/100ps
`default_nettype none
`include "psr_regs.vh"

module psr_nvm_model (
	input wire logic clk,
	input wire logic srst,
	input wire logic nvm_req,
	input wire logic [1:0] nvm_op,
	input wire logic [5:0] nvm_cat,
	input wire logic [31:0] nvm_mark_date,
	input wire logic [31:0] nvm_mark_time,
	input wire logic [7:0] dly,
	output logic nvm_done,
	output logic [31:0] nvm_load_date,
	output logic [31:0] nvm_load_time
);
	// ****************************************************************
	// Store
	// ****************************************************************
	logic [7:0] cnt_reg;
	logic [31:0] cap_date;
	logic [31:0] cap_time;

	initial begin
		cnt_reg = 8'h00;
		cap_date = 32'h0;
		cap_time = 32'h0;
		nvm_done = 1'b0;
		nvm_load_date = 32'h0;
		nvm_load_time = 32'h0;
	end
	always @(posedge clk) begin
		nvm_done <= 1'b0;
		if (srst || !nvm_req || nvm_done) begin
			cnt_reg <= 8'h00;
			// Marker as it stood when the operation was requested
			cap_date <= nvm_mark_date;
			cap_time <= nvm_mark_time;
		end else if (cnt_reg == dly) begin
			nvm_done <= 1'b1;
			if (nvm_op == `PSR_OP_SAVE && nvm_cat[5]) begin
				nvm_load_date <= cap_date;
				nvm_load_time <= cap_time;
			end
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end
endmodule // psr_nvm_model
`default_nettype wire

// file: sim/psr_ctrl_test.sv
// Purpose: Register-level tests of the save/discard/restart controller
// Assumes: Store model answers dly+1 cycles after each request
// Notes: ce is held high throughout
`timescale 1ns/100ps
`default_nettype none
`include "psr_regs.vh"

module psr_ctrl_test;
	// ****************************************************************
	// Bench
	// ****************************************************************
	logic clk, srst, ce, wr, rd, obj_wr_savable, nvm_done, restart_req, irq, nvm_req;
	logic [5:0] addr, nvm_cat;
	logic [1:0] nvm_op;
	logic [7:0] dly;
	logic [31:0] wdata, rdata, nvm_mark_date, nvm_mark_time, nvm_load_date, nvm_load_time;
	int n_fail = 0, n_checks = 0, n_boot = 0, k;
	localparam logic [31:0] DATE = 32'h0a1b2c3d;
	localparam logic [31:0] TIME_V = 32'h00123456;

	psr_ctrl psr_ctrl_i (.clk(clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .obj_wr_savable(obj_wr_savable),
		.nvm_req(nvm_req), .nvm_op(nvm_op), .nvm_cat(nvm_cat),
		.nvm_mark_date(nvm_mark_date), .nvm_mark_time(nvm_mark_time), .nvm_done(nvm_done),
		.nvm_load_date(nvm_load_date), .nvm_load_time(nvm_load_time),
		.restart_req(restart_req), .irq(irq));
	psr_nvm_model psr_nvm_model_i (.clk(clk), .srst(srst), .nvm_req(nvm_req),
		.nvm_op(nvm_op), .nvm_cat(nvm_cat), .nvm_mark_date(nvm_mark_date),
		.nvm_mark_time(nvm_mark_time), .dly(dly), .nvm_done(nvm_done),
		.nvm_load_date(nvm_load_date), .nvm_load_time(nvm_load_time));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) if (restart_req === 1'b1) n_boot <= n_boot + 1;

	task close_out;
		begin
			$display("checks %0d mismatches %0d", n_checks, n_fail);
			if (n_fail == 0 && n_checks > 0) $display("Result: passed");
			else $display("Result: failed");
			$finish;
		end
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		begin
			n_checks++;
			if (seen !== exp) begin
				n_fail++;
				$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task wr_reg(input logic [5:0] a, input logic [31:0] d);
		begin
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
			@(posedge clk);
			wr <= 1'b0;
			@(posedge clk);
		end
	endtask
	task rd_chk(input logic [5:0] a, input logic [31:0] exp);
		begin
			addr <= a;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			#1 chk(rdata, exp);
			@(posedge clk);
		end
	endtask
	task op_chk(input logic [1:0] op, input logic [5:0] cat);
		begin
			#1 chk({nvm_req, nvm_op, nvm_cat}, {1'b1, op, cat});
			@(posedge clk);
		end
	endtask
	task wait_idle;
		begin
			for (int i = 0; i < 400; i++) begin
				#1;
				if (nvm_req === 1'b0) break;
				@(posedge clk);
			end
			chk(nvm_req, 32'h0);
			@(posedge clk);
		end
	endtask
	task do_reset;
		begin
			srst <= 1'b1;
			repeat (4) @(posedge clk);
			srst <= 1'b0;
			wait_idle;
		end
	endtask

	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		close_out;
	end

	initial begin
		ce = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 6'h00;
		wdata = 32'h0;
		obj_wr_savable = 1'b0;
		dly = 8'h14;
		do_reset;
		rd_chk(`PSR_IRQ_STAT_OFS, 32'h4);
		rd_chk(`PSR_MARK_DATE_OFS, 32'h0);
		wr_reg(`PSR_IRQ_EN_OFS, 32'h4);
		chk(irq, 32'h1);
		wr_reg(`PSR_IRQ_EN_OFS, 32'h0);
		chk(irq, 32'h0);
		wr_reg(`PSR_IRQ_CLR_OFS, 32'hf);
		wr_reg(`PSR_IRQ_EN_OFS, 32'h4);
		chk(irq, 32'h0);
		wr_reg(6'h3f, 32'h5);
		rd_chk(6'h3f, 32'h0);
		$display("reset and interrupt test done");
		wr_reg(`PSR_MARK_DATE_OFS, DATE);
		wr_reg(`PSR_MARK_TIME_OFS, TIME_V);
		wr_reg(6'h01, `PSR_KEY_SAVE);
		rd_chk(6'h01, `PSR_KEY_SAVE);
		rd_chk(`PSR_MARK_TIME_OFS, TIME_V);
		wr_reg(6'h03, `PSR_KEY_SAVE);
		wait_idle;
		rd_chk(6'h01, 32'h1);
		rd_chk(6'h03, `PSR_KEY_SAVE);
		rd_chk(`PSR_IRQ_STAT_OFS, 32'h9);
		rd_chk(`PSR_MARK_DATE_OFS, 32'h0);
		do_reset;
		rd_chk(`PSR_MARK_DATE_OFS, DATE);
		rd_chk(`PSR_MARK_TIME_OFS, TIME_V);
		$display("save-all test done");
		dly <= 8'h00;
		for (k = 1; k <= 6; k++) begin
			wr_reg(6'(k), `PSR_KEY_SAVE);
			op_chk(`PSR_OP_SAVE, k == 1 ? 6'h3f : 6'h01 << (k - 2));
			wait_idle;
			rd_chk(6'(k), 32'h1);
		end
		rd_chk(`PSR_MARK_TIME_OFS, 32'h0);
		wr_reg(`PSR_MARK_DATE_OFS, DATE);
		for (k = 1; k <= 6; k++) begin
			wr_reg(6'h10 + 6'(k), `PSR_KEY_DISCARD);
			op_chk(`PSR_OP_ERASE, k == 1 ? 6'h0f : 6'h01 << (k - 2));
			wait_idle;
			rd_chk(6'h10 + 6'(k), `PSR_KEY_DISCARD);
		end
		rd_chk(`PSR_MARK_DATE_OFS, DATE);
		$display("category test done");
		wr_reg(6'h02, 32'h1);
		chk(nvm_req, 32'h0);
		wr_reg(6'h12, `PSR_KEY_SAVE);
		chk(nvm_req, 32'h0);
		wr_reg(`PSR_BOOT_OFS, `PSR_KEY_DISCARD);
		@(posedge clk);
		chk(n_boot, 32'h0);
		wr_reg(`PSR_BOOT_OFS, `PSR_KEY_BOOT);
		@(posedge clk);
		chk(n_boot, 32'h1);
		wr_reg(`PSR_MARK_DATE_OFS, DATE);
		rd_chk(`PSR_MARK_DATE_OFS, DATE);
		obj_wr_savable <= 1'b1;
		@(posedge clk);
		obj_wr_savable <= 1'b0;
		@(posedge clk);
		rd_chk(`PSR_MARK_DATE_OFS, 32'h0);
		$display("key and marker test done");
		close_out;
	end
endmodule // psr_ctrl_test

bind psr_ctrl psr_ctrl_properties psr_ctrl_properties_i (.clk(clk), .srst(srst), .ce(ce),
	.addr(addr), .wdata(wdata), .wr(wr), .obj_wr_savable(obj_wr_savable), .nvm_req(nvm_req),
	.nvm_op(nvm_op), .nvm_cat(nvm_cat), .nvm_mark_date(nvm_mark_date),
	.nvm_mark_time(nvm_mark_time), .nvm_done(nvm_done), .restart_req(restart_req));
`default_nettype wire
